/* File: hdl/hmba_pkg.sv */
// Shared constants and types for the host and multiprocessor bus arbiter
package hmba_pkg;
  // Multiprocessor request lines and identity width
  localparam int HMBA_NUM_LINES = 6;
  localparam int HMBA_ID_W = 3;
  // Identity meaning a lone processor
  localparam logic [2:0] HMBA_ID_SINGLE = 3'h0;
  // Reset values of held state
  localparam logic [2:0] HMBA_ID_RST = 3'h0;
  localparam logic [2:0] HMBA_MASTER_RST = 3'h0;
  // Last request line index
  localparam logic [2:0] HMBA_LAST_LINE = 3'h5;
  // Channel served by each external DMA pair
  localparam int HMBA_DMA_PAIR1_CH = 7;
  localparam int HMBA_DMA_PAIR2_CH = 8;
  // Host grant sequence of the bus master
  typedef enum logic [1:0]
  {
    HMBA_HG_IDLE = 2'b00,
    HMBA_HG_RELEASE = 2'b01,
    HMBA_HG_GRANT = 2'b10
  } hmba_hg_e;
  // Controller register map, byte addresses
  localparam logic [11:0] HMBA_CTRL_OFS = 12'h000;
  localparam logic [11:0] HMBA_STAT_OFS = 12'h004;
  // Control register fields
  localparam int HMBA_C_HBR = 0;
  localparam int HMBA_C_CS = 1;
  localparam int HMBA_C_ROTATING_PRIORITY_SEL = 2;
  localparam int HMBA_C_SUSPEND_BUS_FLOAT = 3;
  localparam int HMBA_C_DMAR = 4;
  localparam int HMBA_C_ID = 6;
  localparam int HMBA_C_PEER = 9;
  localparam logic [31:0] HMBA_CTRL_RST = 32'h0000_0000;
  // Status register fields
  localparam int HMBA_S_HBG = 0;
  localparam int HMBA_S_RDY = 1;
  localparam int HMBA_S_DMAG = 2;
  localparam int HMBA_S_CPA = 4;
  localparam int HMBA_S_BR = 5;
endpackage

/* File: hdl/hmba_if.sv */
// Pin-level link between the processor end and the host end
`timescale 1ns/1ps
interface hmba_if #(parameter int ADDR_W = 32, parameter int DATA_W = 32);
  // Host driven, active low
  logic host_bus_request_b;
  logic chip_select_b;
  logic [1:0] ext_dma_request_b;
  logic suspend_bus_float_b;
  // Straps from the system
  logic [2:0] processor_identity;
  logic rotating_priority_sel;
  // Peer request drivers modelled by the host end
  logic [5:0] peer_br_o;
  logic [5:0] peer_br_oe;
  // Processor drivers
  logic hbg_o;
  logic hbg_oe;
  logic ready_o;
  logic ready_oe;
  logic [1:0] dmag_o;
  logic dmag_oe;
  logic [5:0] br_o;
  logic [5:0] br_oe;
  logic cpa_o;
  logic cpa_oe;
  // External bus, floated when ext_bus_oe is low
  logic [ADDR_W-1:0] ext_addr;
  logic [DATA_W-1:0] ext_wdata;
  logic ext_wr_b;
  logic ext_rd_b;
  logic ext_bus_oe;
  // Resolved wire levels, undriven lines pull high
  logic host_bus_grant_b;
  logic host_access_ready;
  logic [1:0] ext_dma_grant_b;
  logic [5:0] mp_bus_request_b;
  logic core_priority_access_b;
  assign host_bus_grant_b = hbg_oe ? hbg_o : 1'b1;
  assign host_access_ready = ready_oe ? ready_o : 1'b1;
  assign ext_dma_grant_b = dmag_oe ? dmag_o : 2'b11;
  assign core_priority_access_b = cpa_oe ? cpa_o : 1'b1;
  assign mp_bus_request_b = (br_oe & br_o) | (~br_oe & peer_br_oe & peer_br_o)
    | (~br_oe & ~peer_br_oe);
  // Processor end
  modport dev (
    input host_bus_request_b, chip_select_b, ext_dma_request_b, suspend_bus_float_b,
    input processor_identity, rotating_priority_sel,
    input host_bus_grant_b, mp_bus_request_b, core_priority_access_b,
    output hbg_o, hbg_oe, ready_o, ready_oe, dmag_o, dmag_oe, br_o, br_oe,
    output cpa_o, cpa_oe, ext_addr, ext_wdata, ext_wr_b, ext_rd_b, ext_bus_oe
  );
  // Host and peer end
  modport host (
    output host_bus_request_b, chip_select_b, ext_dma_request_b, suspend_bus_float_b,
    output processor_identity, rotating_priority_sel, peer_br_o, peer_br_oe,
    input host_bus_grant_b, host_access_ready, ext_dma_grant_b, mp_bus_request_b,
    input core_priority_access_b, ext_bus_oe
  );
endinterface // hmba_if

/* File: hdl/hmba_dev.sv */
// Processor end: host grant, ready, DMA pairs and multiprocessor arbitration
`timescale 1ns/1ps
module hmba_dev
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins
  hmba_if.dev pins,
  // Core and DMA requests for the external bus
  input wire logic core_ext_req,
  input wire logic dma_ext_req,
  input wire logic core_priority_req,
  input wire logic [ADDR_W-1:0] ext_addr_in,
  input wire logic [DATA_W-1:0] ext_wdata_in,
  input wire logic ext_write,
  // Internal memory status and configuration bit
  input wire logic host_access_busy,
  input wire logic ready_active_drive_sel,
  // External DMA channels
  input wire logic dma_ch7_grant,
  input wire logic dma_ch8_grant,
  output logic dma_ch7_req,
  output logic dma_ch8_req,
  // Status
  output logic ext_access_done,
  output logic bus_master,
  output logic host_granted
);
  import hmba_pkg::*;

  // Refuse widths the external bus cannot carry
  if (ADDR_W < 1 || DATA_W < 1)
  begin : g_bad_width
    $error("hmba_dev: widths must be positive");
  end

  // Identity caught after reset release
  logic [2:0] id_reg, id_next;
  logic id_valid_reg, id_valid_next;
  // Arbitration state, shared view of the bus
  logic [2:0] master_reg, master_next;
  logic master_valid_reg, master_valid_next;
  hmba_hg_e hg_reg, hg_next;
  // Pin drive registers, value and enable
  logic hbg_o_reg, hbg_o_next, hbg_oe_reg, hbg_oe_next;
  logic ready_o_reg, ready_o_next, ready_oe_reg, ready_oe_next;
  logic [1:0] dmag_o_reg, dmag_o_next;
  logic dmag_oe_reg, dmag_oe_next, cpa_oe_reg, cpa_oe_next, bus_oe_reg, bus_oe_next;
  logic [5:0] br_o_reg, br_o_next, br_oe_reg, br_oe_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic wr_b_reg, wr_b_next, rd_b_reg, rd_b_next;
  // User side registers
  logic ch7_req_reg, ch7_req_next, ch8_req_reg, ch8_req_next;
  logic done_reg, done_next, master_out_reg, master_out_next;
  logic granted_reg, granted_next;
  // Decoded pin levels
  logic host_bus_request, cs, suspend_bus_float, cpa_in, single, is_master, own_req, bus_want;
  logic [2:0] own_idx;
  logic [5:0] req_lines;

  // Next line after idx, wrapping past the last line
  function automatic logic [2:0] hmba_wrap(input logic [2:0] idx);
    hmba_wrap = (idx == HMBA_LAST_LINE) ? HMBA_MASTER_RST : idx + 3'h1;
  endfunction

  // Winner among requesters, search start set by priority mode
  function automatic logic [2:0] hmba_pick(input logic [5:0] lines,
    input logic rot, input logic [2:0] last);
    logic [2:0] idx;
    logic found;
    idx = rot ? hmba_wrap(last) : HMBA_MASTER_RST;
    found = 1'b0;
    hmba_pick = HMBA_MASTER_RST;
    for (int i = 0; i < HMBA_NUM_LINES; i++)
    begin
      if (!found && lines[idx])
      begin
        found = 1'b1;
        hmba_pick = idx;
      end
      idx = hmba_wrap(idx);
    end
  endfunction

  // Strap capture, arbitration, host grant and pin drive decisions
  always_comb
  begin
    // Identity taken at the first edge after release, then held
    id_valid_next = 1'b1;
    id_next = id_valid_reg ? id_reg : pins.processor_identity;
    // Synchronous pins used at the rising edge
    host_bus_request = ~pins.host_bus_request_b;
    cs = ~pins.chip_select_b;
    suspend_bus_float = ~pins.suspend_bus_float_b;
    cpa_in = ~pins.core_priority_access_b;
    req_lines = ~pins.mp_bus_request_b;
    single = (id_reg == HMBA_ID_SINGLE);
    // Identity n maps to line n-1 here
    own_idx = id_reg - 3'h1;
    is_master = id_valid_reg && (single || (master_valid_reg && master_reg == own_idx));
    // Background DMA yields to a foreign priority access
    own_req = core_ext_req || (dma_ext_req && !(cpa_in && !cpa_oe_reg));
    bus_want = single ? (core_ext_req || dma_ext_req) : own_req;
    master_next = master_reg;
    master_valid_next = master_valid_reg;
    hg_next = hg_reg;
    if (!host_bus_request && hg_reg == HMBA_HG_IDLE && id_valid_reg && !single)
    begin
      // Owner keeps the bus while it still asks for it
      if ((!master_valid_reg || !req_lines[master_reg]) && (req_lines != 6'h00))
      begin
        master_next = hmba_pick(req_lines, pins.rotating_priority_sel, master_reg);
        master_valid_next = 1'b1;
      end
    end
    // Host grant sequence, run by the master only
    case (hg_reg)
      HMBA_HG_IDLE:
        hg_next = (host_bus_request && is_master) ? HMBA_HG_RELEASE : HMBA_HG_IDLE;
      HMBA_HG_RELEASE:
        hg_next = host_bus_request ? HMBA_HG_GRANT : HMBA_HG_IDLE;
      HMBA_HG_GRANT:
        // Held until the host lets go
        hg_next = host_bus_request ? HMBA_HG_GRANT : HMBA_HG_IDLE;
      default:
        hg_next = HMBA_HG_IDLE;
    endcase
    // Grant driven by the master alone
    hbg_oe_next = (hg_next != HMBA_HG_IDLE);
    hbg_o_next = (hg_next != HMBA_HG_GRANT);
    // Bus driven only by an unsuspended master
    // Suspend floats the bus from the next cycle
    // Released for the host as well
    bus_oe_next = is_master && !suspend_bus_float && !host_bus_request && hg_reg == HMBA_HG_IDLE;
    addr_next = bus_oe_next ? ext_addr_in : addr_reg;
    wdata_next = bus_oe_next ? ext_wdata_in : wdata_reg;
    wr_b_next = !(bus_oe_next && bus_want && ext_write);
    rd_b_next = !(bus_oe_next && bus_want && !ext_write);
    // Access completes only on a driven cycle; suspension stalls it
    done_next = bus_oe_reg && !suspend_bus_float && (!wr_b_reg || !rd_b_reg);
    // Ready only with select and host request
    // Low while internal access is busy
    ready_oe_next = cs && host_bus_request && (host_access_busy || ready_active_drive_sel);
    ready_o_next = !host_access_busy;
    // Pair one for channel 7, pair two for channel 8
    dmag_oe_next = bus_oe_next;
    dmag_o_next = {!dma_ch8_grant, !dma_ch7_grant};
    ch7_req_next = !pins.ext_dma_request_b[0];
    ch8_req_next = !pins.ext_dma_request_b[1];
    // Open-drain: pull low only, never drive high
    // Raised by a slave core wanting the bus
    cpa_oe_next = !single && core_priority_req && core_ext_req && !is_master;
    master_out_next = is_master;
    granted_next = (hg_next == HMBA_HG_GRANT);
  end

  // Own request line drive, one entry per line
  for (genvar g = 0; g < HMBA_NUM_LINES; g++)
  begin : g_br
    always_comb
    begin
      // Only the own line is driven
      br_oe_next[g] = id_valid_reg && !single && (own_idx == 3'(g));
      br_o_next[g] = !own_req;
    end
  end

  // State and pin registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Identity and arbitration start empty, host sequence idle
      id_reg <= HMBA_ID_RST;
      master_reg <= HMBA_MASTER_RST;
      hg_reg <= HMBA_HG_IDLE;
      {id_valid_reg, master_valid_reg, cpa_oe_reg, bus_oe_reg} <= 4'h0;
      // Every driver off, pin values and strobes at their idle high level
      {hbg_oe_reg, ready_oe_reg, dmag_oe_reg, br_oe_reg} <= 9'h000;
      {hbg_o_reg, ready_o_reg, wr_b_reg, rd_b_reg, dmag_o_reg, br_o_reg} <= 12'hfff;
      addr_reg <= '0;
      wdata_reg <= '0;
      {ch7_req_reg, ch8_req_reg, done_reg, master_out_reg, granted_reg} <= 5'h00;
    end
    else
    begin
      id_reg <= id_next;
      id_valid_reg <= id_valid_next;
      master_reg <= master_next;
      master_valid_reg <= master_valid_next;
      hg_reg <= hg_next;
      hbg_o_reg <= hbg_o_next;
      hbg_oe_reg <= hbg_oe_next;
      ready_o_reg <= ready_o_next;
      ready_oe_reg <= ready_oe_next;
      dmag_o_reg <= dmag_o_next;
      dmag_oe_reg <= dmag_oe_next;
      br_o_reg <= br_o_next;
      br_oe_reg <= br_oe_next;
      cpa_oe_reg <= cpa_oe_next;
      bus_oe_reg <= bus_oe_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_b_reg <= wr_b_next;
      rd_b_reg <= rd_b_next;
      ch7_req_reg <= ch7_req_next;
      ch8_req_reg <= ch8_req_next;
      done_reg <= done_next;
      master_out_reg <= master_out_next;
      granted_reg <= granted_next;
    end
  end

  // Pins straight from flops; the priority line only ever pulls low
  assign {pins.hbg_o, pins.hbg_oe} = {hbg_o_reg, hbg_oe_reg};
  assign {pins.ready_o, pins.ready_oe} = {ready_o_reg, ready_oe_reg};
  assign {pins.dmag_o, pins.dmag_oe} = {dmag_o_reg, dmag_oe_reg};
  assign {pins.br_o, pins.br_oe} = {br_o_reg, br_oe_reg};
  assign {pins.cpa_o, pins.cpa_oe} = {1'b0, cpa_oe_reg};
  assign {pins.ext_addr, pins.ext_wdata} = {addr_reg, wdata_reg};
  assign {pins.ext_wr_b, pins.ext_rd_b, pins.ext_bus_oe} = {wr_b_reg, rd_b_reg, bus_oe_reg};
  assign {dma_ch7_req, dma_ch8_req} = {ch7_req_reg, ch8_req_reg};
  assign ext_access_done = done_reg;
  assign {bus_master, host_granted} = {master_out_reg, granted_reg};
endmodule // hmba_dev

/* File: hdl/hmba_host.sv */
// Host end: APB-controlled host and peer request pins
`timescale 1ns/1ps
module hmba_host
  import hmba_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  hmba_if.host pins
);
  import hmba_pkg::*;

  // Control register and registered read answer
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic rdy_reg, rdy_next;
  logic [31:0] status;
  logic hit_ctrl, hit_stat, setup;

  // Decode and answer one cycle after setup, no wait states
  always_comb
  begin
    // Status from resolved pin levels, active high
    status = '0;
    status[HMBA_S_HBG] = !pins.host_bus_grant_b;
    status[HMBA_S_RDY] = pins.host_access_ready;
    status[HMBA_S_DMAG +: 2] = ~pins.ext_dma_grant_b;
    status[HMBA_S_CPA] = !pins.core_priority_access_b;
    status[HMBA_S_BR +: 6] = ~pins.mp_bus_request_b;
    setup = psel && !penable;
    hit_ctrl = (paddr == HMBA_CTRL_OFS);
    hit_stat = (paddr == HMBA_STAT_OFS);
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    rdy_next = setup;
    if (setup)
    begin
      // Unmapped address answers with an error
      err_next = !(hit_ctrl || hit_stat) || (pwrite && hit_stat);
      rdata_next = hit_ctrl ? ctrl_reg : (hit_stat ? status : 32'h0000_0000);
    end
    // Write lands at the completing edge
    if (psel && penable && rdy_reg && pwrite && hit_ctrl)
      ctrl_next = pwdata;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= HMBA_CTRL_RST;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      rdy_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      rdy_reg <= rdy_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = rdy_reg;
  assign pslverr = err_reg && rdy_reg;
  // Host bus request from control bit
  assign pins.host_bus_request_b = !ctrl_reg[HMBA_C_HBR];
  assign pins.chip_select_b = !ctrl_reg[HMBA_C_CS];
  // One select level shared by every processor
  assign pins.rotating_priority_sel = ctrl_reg[HMBA_C_ROTATING_PRIORITY_SEL];
  assign pins.suspend_bus_float_b = !ctrl_reg[HMBA_C_SUSPEND_BUS_FLOAT];
  assign pins.ext_dma_request_b = ~ctrl_reg[HMBA_C_DMAR +: 2];
  assign pins.processor_identity = ctrl_reg[HMBA_C_ID +: 3];
  // Peers pull low when requesting, else line floats high
  assign pins.peer_br_o = 6'h00;
  assign pins.peer_br_oe = ctrl_reg[HMBA_C_PEER +: 6];
endmodule // hmba_host

/* File: verif/hmba_chk.sv */
// Pin-level checker for the host and multiprocessor arbiter link
`timescale 1ns/1ps
module hmba_chk
(
  // Clock and device reset
  input wire logic clk,
  input wire logic rst_b,
  // Host side pins
  input wire logic host_bus_request_b,
  input wire logic chip_select_b,
  input wire logic suspend_bus_float_b,
  input wire logic [2:0] processor_identity,
  // Processor drivers
  input wire logic hbg_o,
  input wire logic hbg_oe,
  input wire logic ready_oe,
  input wire logic [5:0] br_oe,
  input wire logic cpa_o,
  input wire logic cpa_oe,
  input wire logic ext_bus_oe
);
  // Whole checker runs in the processor clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Grant low never overlaps a driven bus
  chk_grant_floats_bus: assert property ((hbg_oe && !hbg_o) |-> !ext_bus_oe)
    else $error("host grant while bus driven");
  // Master answers host request in bounded time
  chk_grant_latency: assert property (($fell(host_bus_request_b) && ext_bus_oe)
    |-> ##[1:3] (hbg_oe && !hbg_o))
    else $error("host grant late");
  // Grant kept while host still requests
  chk_grant_held: assert property ((hbg_oe && !hbg_o && !host_bus_request_b)
    |=> (hbg_oe && !hbg_o))
    else $error("host grant dropped early");
  // Grant driver let go after request ends
  chk_grant_release: assert property ((hbg_oe && $rose(host_bus_request_b))
    |-> ##[1:2] !hbg_oe)
    else $error("host grant not released");
  // Ready only driven with select and request, one cycle late
  chk_ready_qual: assert property (ready_oe |-> ($past(chip_select_b) == 1'b0
    && $past(host_bus_request_b) == 1'b0))
    else $error("ready driven without select and request");
  // Suspend floats the bus from next cycle
  chk_suspend_float: assert property (!suspend_bus_float_b |=> !ext_bus_oe)
    else $error("bus driven while suspended");
  // Only the identity line is ever driven
  chk_own_line: assert property ((br_oe != 6'h0) |-> (processor_identity != 3'h0
    && br_oe == (6'h1 << (processor_identity - 3'h1))))
    else $error("wrong request line driven");
  // Priority access line only ever pulls low
  chk_cpa_drain: assert property (cpa_oe |-> (!cpa_o && !ext_bus_oe))
    else $error("priority access driven high");
endmodule // hmba_chk

/* File: verif/host_and_multiproc_bus_arbiter_test.sv */
// Testbench for both ends of the host and multiprocessor arbiter
`timescale 1ns/1ps
module host_and_multiproc_bus_arbiter_test;
  import hmba_pkg::*;
  logic clk, rst_b, dev_rst_b;
  // APB master
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // Processor user side
  logic core_ext_req, dma_ext_req, core_priority_req, ext_write;
  logic [31:0] ext_addr_in, ext_wdata_in;
  logic host_access_busy, ready_active_drive_sel, dma_ch7_grant, dma_ch8_grant;
  logic dma_ch7_req, dma_ch8_req, ext_access_done, bus_master, host_granted;
  int mismatches, total_checks;
  logic [31:0] rd;
  logic err;

  hmba_if i_hmba_if ();
  hmba_dev i_hmba_dev (.clk(clk), .rst_b(dev_rst_b), .pins(i_hmba_if.dev),
    .core_ext_req(core_ext_req), .dma_ext_req(dma_ext_req),
    .core_priority_req(core_priority_req), .ext_addr_in(ext_addr_in),
    .ext_wdata_in(ext_wdata_in), .ext_write(ext_write),
    .host_access_busy(host_access_busy), .ready_active_drive_sel(ready_active_drive_sel),
    .dma_ch7_grant(dma_ch7_grant), .dma_ch8_grant(dma_ch8_grant),
    .dma_ch7_req(dma_ch7_req), .dma_ch8_req(dma_ch8_req),
    .ext_access_done(ext_access_done), .bus_master(bus_master),
    .host_granted(host_granted));
  hmba_host i_hmba_host (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(i_hmba_if.host));
  hmba_chk i_hmba_chk (.clk(clk), .rst_b(dev_rst_b),
    .host_bus_request_b(i_hmba_if.host_bus_request_b),
    .chip_select_b(i_hmba_if.chip_select_b),
    .suspend_bus_float_b(i_hmba_if.suspend_bus_float_b),
    .processor_identity(i_hmba_if.processor_identity), .hbg_o(i_hmba_if.hbg_o),
    .hbg_oe(i_hmba_if.hbg_oe), .ready_oe(i_hmba_if.ready_oe), .br_oe(i_hmba_if.br_oe),
    .cpa_o(i_hmba_if.cpa_o), .cpa_oe(i_hmba_if.cpa_oe),
    .ext_bus_oe(i_hmba_if.ext_bus_oe));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; values read just after an edge are those the edge sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, HMBA_CTRL_OFS, v);
    tick(3);
  endtask

  // Identity is latched once, so change it with the processor held in reset
  task automatic set_id(input logic [31:0] v);
    dev_rst_b <= 1'b0;
    ctrl(v);
    dev_rst_b <= 1'b1;
    tick(6);
  endtask

  // Register access, refusals
  task automatic t_regs();
    apb(1'b0, HMBA_CTRL_OFS, 32'h0);
    chk("ctrl_reset", rd, HMBA_CTRL_RST);
    apb(1'b1, HMBA_CTRL_OFS, 32'h0000_0004);
    apb(1'b0, HMBA_CTRL_OFS, 32'h0);
    chk("ctrl_back", rd, 32'h0000_0004);
    apb(1'b1, HMBA_STAT_OFS, 32'h0000_ffff);
    chk("stat_wr_err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    ctrl(32'h0);
  endtask

  // Host takes the bus from a lone processor
  task automatic t_host();
    int n;
    tick(4);
    chk("lone_master", {31'h0, bus_master}, 32'h1);
    ctrl(32'h0000_0001);
    for (n = 0; n < 20 && i_hmba_if.host_bus_grant_b !== 1'b0; n++)
      @(posedge clk);
    chk("grant_low", {31'h0, i_hmba_if.host_bus_grant_b}, 32'h0);
    chk("bus_floated", {31'h0, i_hmba_if.ext_bus_oe}, 32'h0);
    chk("host_granted", {31'h0, host_granted}, 32'h1);
    chk("lone_no_br", {26'h0, i_hmba_if.br_oe}, 32'h0);
    tick(5);
    chk("grant_kept", {31'h0, i_hmba_if.host_bus_grant_b}, 32'h0);
    ctrl(32'h0);
    chk("grant_gone", {31'h0, i_hmba_if.host_bus_grant_b}, 32'h1);
  endtask

  // Wait states, drive kind and qualification of ready
  task automatic t_ready();
    host_access_busy <= 1'b1;
    ctrl(32'h0000_0003);
    chk("ready_wait", {31'h0, i_hmba_if.host_access_ready}, 32'h0);
    host_access_busy <= 1'b0;
    tick(3);
    chk("ready_drain", {31'h0, i_hmba_if.ready_oe}, 32'h0);
    ready_active_drive_sel <= 1'b1;
    tick(3);
    chk("ready_active", {31'h0, i_hmba_if.ready_oe}, 32'h1);
    chk("ready_high", {31'h0, i_hmba_if.host_access_ready}, 32'h1);
    ctrl(32'h0000_0001);
    chk("ready_no_cs", {31'h0, i_hmba_if.ready_oe}, 32'h0);
    ready_active_drive_sel <= 1'b0;
    ctrl(32'h0);
  endtask

  // Each external DMA pair reaches its own channel
  task automatic t_dma();
    for (int k = 1; k < 3; k++)
    begin
      ctrl(32'(k) << HMBA_C_DMAR);
      chk("dma_req", {30'h0, dma_ch8_req, dma_ch7_req}, 32'(k));
    end
    ctrl(32'h0);
    dma_ch7_grant <= 1'b1;
    tick(3);
    chk("dma_grant", {30'h0, i_hmba_if.ext_dma_grant_b}, 32'h2);
    dma_ch7_grant <= 1'b0;
    dma_ch8_grant <= 1'b1;
    tick(3);
    chk("dma_grant2", {30'h0, i_hmba_if.ext_dma_grant_b}, 32'h1);
    dma_ch8_grant <= 1'b0;
  endtask

  // Suspend floats the bus and stalls accesses
  task automatic t_suspend();
    ctrl(32'h0000_0008);
    chk("susp_float", {31'h0, i_hmba_if.ext_bus_oe}, 32'h0);
    chk("susp_stall", {31'h0, ext_access_done}, 32'h0);
    ctrl(32'h0);
    tick(3);
    chk("susp_back", {31'h0, i_hmba_if.ext_bus_oe}, 32'h1);
    chk("read_done", {31'h0, ext_access_done}, 32'h1);
    chk("bus_addr", i_hmba_if.ext_addr, 32'h0000_0100);
    ext_write <= 1'b1;
    tick(3);
    chk("wr_strobe", {30'h0, i_hmba_if.ext_wr_b, i_hmba_if.ext_rd_b}, 32'h1);
    chk("bus_wdata", i_hmba_if.ext_wdata, 32'h5a5a_0f0f);
    chk("write_done", {31'h0, ext_access_done}, 32'h1);
    ext_write <= 1'b0;
  endtask

  // Each identity 1 to 6 drives only its own request line
  task automatic t_ids();
    for (int i = 1; i < 7; i++)
    begin
      set_id(32'(i) << HMBA_C_ID);
      chk("own_oe", {26'h0, i_hmba_if.br_oe}, 32'h1 << (i - 1));
      chk("own_line", {26'h0, i_hmba_if.mp_bus_request_b},
        {26'h0, ~(6'h1 << (i - 1))});
    end
  endtask

  // Fixed against rotating choice after the owner drops out
  task automatic t_prio();
    logic [31:0] b;
    for (int m = 0; m < 2; m++)
    begin
      b = (32'h3 << HMBA_C_ID) | (32'(m) << HMBA_C_ROTATING_PRIORITY_SEL);
      set_id(b);
      ctrl(b | 32'h2200);
      chk("owner_keeps", {31'h0, bus_master}, 32'h1);
      core_ext_req <= 1'b0;
      tick(6);
      core_ext_req <= 1'b1;
      tick(6);
      chk("slave_float", {31'h0, i_hmba_if.ext_bus_oe}, 32'h0);
      core_priority_req <= 1'b1;
      tick(4);
      chk("cpa_low", {31'h0, i_hmba_if.core_priority_access_b}, 32'h0);
      core_priority_req <= 1'b0;
      ctrl(b | 32'h2000);
      tick(5);
      chk("winner", {31'h0, bus_master}, 32'(1 - m));
      ctrl(b);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    tick(20000);
    mismatches++;
    summarize();
  end

  // Main sequence
  initial
  begin
    mismatches = 0;
    total_checks = 0;
    rst_b = 1'b0;
    dev_rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {core_ext_req, dma_ext_req, core_priority_req, ext_write} = 4'h8;
    ext_addr_in = 32'h0000_0100;
    ext_wdata_in = 32'h5a5a_0f0f;
    {host_access_busy, ready_active_drive_sel, dma_ch7_grant, dma_ch8_grant} = 4'h0;
    tick(6);
    rst_b <= 1'b1;
    dev_rst_b <= 1'b1;
    tick(2);
    t_regs();
    t_host();
    t_ready();
    t_dma();
    t_suspend();
    t_ids();
    t_prio();
    summarize();
  end
endmodule // host_and_multiproc_bus_arbiter_test
